// File: i2c_host_model.sv
// Purpose: two-wire bus master standing in for the host processor
// Assumes: open-drain line resolved outside, pull-up high
// Notes:   one bit slot is 8 core cycles, 400 ns
`timescale 1ns/100ps
module i2c_host_model (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  reg [7:0] rd [0:7];
  reg       nak;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task q;
    repeat (2) @(posedge clk);
  endtask
  // data moves only while scl is low, sampled late in the high phase
  task bit_slot(input b, output r);
    begin
      q;
      sda_low <= !b;
      q;
      scl <= 1'b1;
      q;
      q;
      r = sda;
      scl <= 1'b0;
    end
  endtask
  task byte_out(input [7:0] b);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_slot(b[i], r);
      bit_slot(1'b1, r);
      nak = nak | r;
    end
  endtask
  task byte_in(input last, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_slot(1'b1, d[i]);
      bit_slot(last, r);
    end
  endtask
  // first and repeated start alike
  task bus_start;
    begin
      q;
      sda_low <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b1;
      q;
      scl <= 1'b0;
    end
  endtask
  task bus_stop;
    begin
      q;
      sda_low <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b0;
      q;
    end
  endtask
  task wr(input [6:0] dev, input [7:0] a, input [7:0] d);
    begin
      nak = 1'b0;
      bus_start;
      byte_out({dev, 1'b0});
      byte_out(a);
      byte_out(d);
      bus_stop;
    end
  endtask
  task rdn(input [6:0] dev, input [7:0] a, input integer n);
    integer k;
    begin
      nak = 1'b0;
      bus_start;
      byte_out({dev, 1'b0});
      byte_out(a);
      bus_start;
      byte_out({dev, 1'b1});
      for (k = 0; k < n; k = k + 1)
        byte_in(k == n - 1, rd[k]);
      bus_stop;
    end
  endtask
endmodule

// File: mag_core.v
// Purpose: mode control, result registers and two-wire slave of a 3-axis field sensor
// Assumes: scl/sda and the address strap come from outside the clock domain
// Notes:   converter words arrive as x, y, z, temperature, each 16 bits
// Notes on behaviour
// - power-up clears registers, enters standby
// - bus ready within 250 us of power
// - slave address 010110 plus strap bit
// - slave works at 100 and 400 kHz
// - control 09H mode bits select mode
// - mode 01 measures repeatedly into outputs
// - rate field 01 gives 50 Hz
// - range field 10 gives 12 gauss
// - oversample defaults 00; 10=128, 11=64
// - data register read clears both flags
// - data read locks outputs until 05H read
// - x low read latches; flags follow 05H
// - read mid-measurement returns old data
// - unread result overwritten, skipped flag set
// - locked outputs discard new result, skipped
// - standby keeps registers, bus, halts clock
// - 0x32 to 09H starts self-test
// - 0x0F in 0BH: set/reset per 65
// - 0x3D to 09H starts continuous 200 Hz
// - 0x00 to 09H returns standby
// - 0x80 to 0AH soft resets to standby
// - flags bit 0 shows new result
// - ready set after all axes loaded
// - register address increments per byte
// - 09H fields osr, range, rate, mode
`timescale 1ns/100ps
`include "mag_defs.vh"
module mag_core #(
  parameter POR_CYC  = `POR_CYCLES,
  parameter P10      = `RATE_10HZ_CYCLES,
  parameter P50      = `RATE_50HZ_CYCLES,
  parameter P100     = `RATE_100HZ_CYCLES,
  parameter P200     = `RATE_200HZ_CYCLES,
  parameter WORD_W   = 16,
  parameter FIFO_D   = 8
) (
  input  wire              clk,
  input  wire              arst_n,
  input  wire              scl_in,
  input  wire              sda_in,
  output reg               sda_out,
  output reg               sda_oe,
  input  wire              address_select_pin,
  input  wire              sample_valid,
  input  wire [WORD_W-1:0] sample_data,
  output wire              sample_ready,
  output wire              measure_start,
  output wire              setreset_pulse,
  output reg               selftest_drive,
  output reg               osc_run,
  output reg               bus_ready
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_WBYTE = 3'h3;
  localparam ST_WACK  = 3'h4;
  localparam ST_RBYTE = 3'h5;
  localparam ST_RACK  = 3'h6;

  reg [7:0]  result_mem [0:5];
  reg [7:0]  temp_low_reg;
  reg [7:0]  temp_high_reg;
  reg [7:0]  op_ctrl_reg;
  reg        rollover_reg;
  reg [7:0]  sr_period_reg;
  reg        ready_flag_reg;
  reg        skipped_flag_reg;
  reg        lock_reg;
  reg [15:0] pend [0:3];
  reg [1:0]  word_cnt_reg;
  reg        measuring_reg;
  reg [12:0] por_cnt_reg;
  reg        scl_s1;
  reg        scl_s2;
  reg        scl_d;
  reg        sda_s1;
  reg        sda_s2;
  reg        sda_d;
  reg        strap_s1;
  reg        strap_s2;
  reg [2:0]  state_reg;
  reg [2:0]  bit_cnt_reg;
  reg [7:0]  shift_reg;
  reg [7:0]  ptr_reg;
  reg        ptr_phase_reg;
  reg        ack_drv_reg;
  reg        master_ack_reg;
  reg        rd_evt;
  reg [7:0]  rd_addr;
  reg        wr_evt;
  reg [7:0]  wr_addr;
  reg [7:0]  wr_data;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire       fifo_valid;
  wire [WORD_W-1:0] fifo_data;
  wire       pop;
  wire       commit;
  wire [7:0] shift_next;
  integer    i;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, reserved bits and unmapped addresses read zero
  function [7:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05: read_mux = result_mem[a[2:0]];
        `OFF_FLAGS:     read_mux = {5'h00, skipped_flag_reg, 1'b0, ready_flag_reg};
        `OFF_TEMP_LOW:  read_mux = temp_low_reg;
        `OFF_TEMP_HIGH: read_mux = temp_high_reg;
        `OFF_OP_CTRL:   read_mux = op_ctrl_reg;
        `OFF_RST_CTRL:  read_mux = {1'b0, rollover_reg, 6'h00};
        `OFF_SR_PERIOD: read_mux = sr_period_reg;
        default:        read_mux = 8'h00;
      endcase
    end
  endfunction

  // next pointer, with the optional 00H..06H wrap
  function [7:0] ptr_inc;
    input [7:0] a;
    input       roll;
    begin
      if (roll && a == `OFF_FLAGS) begin
        ptr_inc = `OFF_X_LOW;
      end else begin
        ptr_inc = a + 8'h01;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; logic reads the second stage and the delayed copy after it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1   <= 1'b1;
      scl_s2   <= 1'b1;
      scl_d    <= 1'b1;
      sda_s1   <= 1'b1;
      sda_s2   <= 1'b1;
      sda_d    <= 1'b1;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      scl_s1   <= scl_in;
      scl_s2   <= scl_s1;
      scl_d    <= scl_s2;
      sda_s1   <= sda_in;
      sda_s2   <= sda_s1;
      sda_d    <= sda_s2;
      strap_s1 <= address_select_pin;
      strap_s2 <= strap_s1;
    end
  end

  // 20 MHz sampling gives 50 samples per fast-mode bit, ample margin
  assign scl_rise   = scl_s2 & ~scl_d;
  assign scl_fall   = ~scl_s2 & scl_d;
  assign bus_start  = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop   = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign shift_next = {shift_reg[6:0], sda_s2};

  ////////////////////////////////////////////////////////////////////////////
  // power-on delay; the bus is ignored until it expires
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_reg <= 13'h0000;
      bus_ready   <= 1'b0;
    end else if (!bus_ready) begin
      if (por_cnt_reg >= POR_CYC - 1) begin
        bus_ready <= 1'b1;
      end else begin
        por_cnt_reg <= por_cnt_reg + 13'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave protocol engine; sda is open drain, so oe low means released
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 8'h00;
      ptr_reg        <= 8'h00;
      ptr_phase_reg  <= 1'b0;
      ack_drv_reg    <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
      rd_evt         <= 1'b0;
      rd_addr        <= 8'h00;
      wr_evt         <= 1'b0;
      wr_addr        <= 8'h00;
      wr_data        <= 8'h00;
    end else begin
      rd_evt <= 1'b0;
      wr_evt <= 1'b0;
      if (bus_stop || !bus_ready) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (bus_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 3'h0;
        sda_oe      <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                if (shift_next[7:1] == {`ADDR_UPPER, strap_s2}) begin
                  state_reg   <= ST_AACK;
                  ack_drv_reg <= 1'b0;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              if (!ack_drv_reg) begin
                ack_drv_reg <= 1'b1;
                sda_oe      <= 1'b1;
              end else if (state_reg == ST_AACK && shift_reg[0]) begin
                // read: the fall that ends the ack puts out the first bit
                sda_oe      <= read_mux(ptr_reg) < 8'h80;
                shift_reg   <= read_mux(ptr_reg);
                rd_evt      <= 1'b1;
                rd_addr     <= ptr_reg;
                ptr_reg     <= ptr_inc(ptr_reg, rollover_reg);
                bit_cnt_reg <= 3'h0;
                state_reg   <= ST_RBYTE;
              end else begin
                ptr_phase_reg <= (state_reg == ST_AACK);
                sda_oe        <= 1'b0;
                bit_cnt_reg   <= 3'h0;
                state_reg     <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shift_reg   <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                if (ptr_phase_reg) begin
                  ptr_reg <= shift_next;
                end else begin
                  wr_evt  <= 1'b1;
                  wr_addr <= ptr_reg;
                  wr_data <= shift_next;
                  ptr_reg <= ptr_inc(ptr_reg, rollover_reg);
                end
                ptr_phase_reg <= 1'b0;
                ack_drv_reg   <= 1'b0;
                state_reg     <= ST_WACK;
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h7) begin
                sda_oe    <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                sda_oe      <= ~shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack_reg <= ~sda_s2;
            end else if (scl_fall) begin
              if (master_ack_reg) begin
                sda_oe      <= read_mux(ptr_reg) < 8'h80;
                shift_reg   <= read_mux(ptr_reg);
                rd_evt      <= 1'b1;
                rd_addr     <= ptr_reg;
                ptr_reg     <= ptr_inc(ptr_reg, rollover_reg);
                bit_cnt_reg <= 3'h0;
                state_reg   <= ST_RBYTE;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter words are buffered; the assembler drains only while measuring
  sample_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_D),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .in_ready  (sample_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (measuring_reg)
  );

  meas_timer #(
    .P10  (P10),
    .P50  (P50),
    .P100 (P100),
    .P200 (P200)
  ) u_timer (
    .clk            (clk),
    .arst_n         (arst_n),
    .mode           (op_ctrl_reg[`FLD_MODE_LO+1:`FLD_MODE_LO]),
    .rate           (op_ctrl_reg[`FLD_RATE_LO+1:`FLD_RATE_LO]),
    .sr_period      (sr_period_reg),
    .busy           (measuring_reg),
    .start_pulse    (measure_start),
    .setreset_pulse (setreset_pulse)
  );

  assign pop    = fifo_valid & measuring_reg;
  assign commit = pop & (word_cnt_reg == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // measurement assembly and result commit
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      measuring_reg <= 1'b0;
      word_cnt_reg  <= 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        pend[i] <= 16'h0000;
      end
    end else begin
      if (measure_start) begin
        measuring_reg <= 1'b1;
        word_cnt_reg  <= 2'h0;
      end else if (pop) begin
        pend[word_cnt_reg] <= fifo_data[15:0];
        word_cnt_reg       <= word_cnt_reg + 2'h1;
        if (commit) begin
          measuring_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file, flags and data lock; a commit beats a clearing read
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 6; i = i + 1) begin
        result_mem[i] <= 8'h00;
      end
      temp_low_reg     <= 8'h00;
      temp_high_reg    <= 8'h00;
      op_ctrl_reg      <= `RST_OP_CTRL;
      rollover_reg     <= 1'b0;
      sr_period_reg    <= `RST_SR_PERIOD;
      ready_flag_reg   <= 1'b0;
      skipped_flag_reg <= 1'b0;
      lock_reg         <= 1'b0;
      selftest_drive   <= 1'b0;
      osc_run          <= 1'b0;
    end else begin
      // reads first, so a same-cycle commit overrides them
      if (rd_evt && rd_addr <= `OFF_Z_HIGH) begin
        ready_flag_reg   <= 1'b0;
        skipped_flag_reg <= 1'b0;
        lock_reg         <= (rd_addr != `OFF_Z_HIGH);
      end
      if (rd_evt && rd_addr == `OFF_FLAGS) begin
        skipped_flag_reg <= 1'b0;
      end
      if (commit) begin
        // results sit unchanged while a measurement runs
        if (lock_reg && !(rd_evt && rd_addr == `OFF_Z_HIGH)) begin
          skipped_flag_reg <= 1'b1;
        end else begin
          result_mem[0] <= pend[0][7:0];
          result_mem[1] <= pend[0][15:8];
          result_mem[2] <= pend[1][7:0];
          result_mem[3] <= pend[1][15:8];
          result_mem[4] <= pend[2][7:0];
          result_mem[5] <= pend[2][15:8];
          temp_low_reg  <= fifo_data[7:0];
          temp_high_reg <= fifo_data[15:8];
          ready_flag_reg <= 1'b1;
          if (ready_flag_reg && !(rd_evt && rd_addr <= `OFF_Z_HIGH)) begin
            skipped_flag_reg <= 1'b1;
          end
        end
      end
      if (wr_evt) begin
        case (wr_addr)
          `OFF_OP_CTRL: op_ctrl_reg <= wr_data;
          `OFF_RST_CTRL: begin
            rollover_reg <= wr_data[`FLD_ROLLOVER];
            if (wr_data[`FLD_SOFT_RST]) begin
              // soft reset: defaults back, standby entered
              op_ctrl_reg      <= `RST_OP_CTRL;
              rollover_reg     <= 1'b0;
              sr_period_reg    <= `RST_SR_PERIOD;
              ready_flag_reg   <= 1'b0;
              skipped_flag_reg <= 1'b0;
              lock_reg         <= 1'b0;
            end
          end
          `OFF_SR_PERIOD: sr_period_reg <= wr_data;
          default: begin
          end
        endcase
      end
      // standby halts the oscillator; self-test drives the test coil
      osc_run        <= (op_ctrl_reg[1:0] == `MODE_CONT) |
                        (op_ctrl_reg[1:0] == `MODE_SELFTEST);
      selftest_drive <= (op_ctrl_reg[1:0] == `MODE_SELFTEST);
    end
  end
endmodule

// File: mag_core_props.sv
// Purpose: pin-level timing checks on the sensor core
// Assumes: single clock, bound from the bench top file
// Notes:   POR_CYC must match the bound instance
`timescale 1ns/100ps
module mag_core_props #(
  parameter POR_CYC = 20
) (
  input wire clk,
  input wire arst_n,
  input wire sda_out,
  input wire sda_oe,
  input wire measure_start,
  input wire setreset_pulse,
  input wire selftest_drive,
  input wire osc_run,
  input wire bus_ready
);
  reg [15:0] up_cnt;
  // cycles since reset release, saturating so it never wraps
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      up_cnt <= 16'h0000;
    else if (up_cnt != 16'hFFFF)
      up_cnt <= up_cnt + 16'h0001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_open_drain; sda_oe |-> !sda_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  property p_quiet_early; !bus_ready |-> !sda_oe; endproperty
  a_quiet_early: assert property (p_quiet_early) else $error("ack before ready");
  property p_por_bound; (up_cnt > POR_CYC + 4) |-> bus_ready; endproperty
  a_por_bound: assert property (p_por_bound) else $error("bus ready late");
  property p_ready_kept; bus_ready |=> bus_ready; endproperty
  a_ready_kept: assert property (p_ready_kept) else $error("bus ready dropped");
  property p_start_pulse; measure_start |=> !measure_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_idle_still; measure_start |-> osc_run; endproperty
  a_idle_still: assert property (p_idle_still) else $error("start in standby");
  property p_sr_start; setreset_pulse |-> measure_start; endproperty
  a_sr_start: assert property (p_sr_start) else $error("set/reset alone");
  property p_test_runs; selftest_drive |-> osc_run; endproperty
  a_test_runs: assert property (p_test_runs) else $error("self-test halted");
endmodule

// File: mag_defs.vh
// Purpose: shared offsets, fields, reset values and timing counts of the sensor core
// Assumes: 20 MHz core clock
// Notes:   included by mag_core and meas_timer; sample_fifo does without it
`ifndef MAG_DEFS_VH
`define MAG_DEFS_VH

`define CLK_HZ            20000000
// register offsets
`define OFF_X_LOW         8'h00
`define OFF_Z_HIGH        8'h05
`define OFF_FLAGS         8'h06
`define OFF_TEMP_LOW      8'h07
`define OFF_TEMP_HIGH     8'h08
`define OFF_OP_CTRL       8'h09
`define OFF_RST_CTRL      8'h0A
`define OFF_SR_PERIOD     8'h0B
// slave address, upper six bits fixed
`define ADDR_UPPER        6'h16
// operating control fields, msb to lsb: oversample, range, rate, mode
`define FLD_MODE_LO       0
`define FLD_RATE_LO       2
`define FLD_RANGE_LO      4
`define FLD_OSR_LO        6
`define MODE_STANDBY      2'h0
`define MODE_CONT         2'h1
`define MODE_SELFTEST     2'h2
// reset control fields
`define FLD_SOFT_RST      7
`define FLD_ROLLOVER      6
// flags register fields
`define FLD_READY         0
`define FLD_SKIPPED       2
// reset values
`define RST_OP_CTRL       8'h00
`define RST_RST_CTRL      8'h00
`define RST_SR_PERIOD     8'h00
// timing
`define POR_TIME_US       250
`define POR_CYCLES        ((`POR_TIME_US * (`CLK_HZ / 1000000)))
`define RATE_10HZ_CYCLES  (`CLK_HZ / 10)
`define RATE_50HZ_CYCLES  (`CLK_HZ / 50)
`define RATE_100HZ_CYCLES (`CLK_HZ / 100)
`define RATE_200HZ_CYCLES (`CLK_HZ / 200)
// set/reset spacing: measurements per set/reset = 4 * period register + 5, except FFH, which gives 1
`define SR_SCALE          4
`define SR_OFFSET         5

`endif

// File: magnetometer_mode_and_readout_bench.sv
// Purpose: register-level tests of the sensor core through its bus
// Assumes: host model drives the bus, bench feeds converter words
// Notes:   measurement period cut to 4000 cycles
`timescale 1ns/100ps
module magnetometer_mode_and_readout_bench;
  reg        clk;
  reg        arst_n;
  reg        strap;
  reg        sample_valid;
  reg [15:0] sample_data;
  wire       scl;
  wire       host_low;
  wire       sda_oe;
  wire       sda_out;
  wire       sda;
  integer    fails;
  integer    num_checks;
  integer    n;
  reg [7:0]  keep;
  // pull-up: either party may only pull low
  assign sda = !((sda_oe && !sda_out) || host_low);
  mag_core #(.POR_CYC(20), .P200(4000)) dut_u (.clk(clk), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(strap),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(),
    .measure_start(), .setreset_pulse(), .selftest_drive(), .osc_run(), .bus_ready());
  i2c_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  // converter stand-in: each accepted word is one above the last
  always @(posedge clk)
    if (sample_valid && dut_u.sample_ready)
      sample_data <= sample_data + 16'h0001;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog, about twice the expected run
  initial begin
    #3000000;
    fails = fails + 1;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    num_checks = 0;
    arst_n = 1'b0;
    strap = 1'b1;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk({7'h00, dut_u.bus_ready}, 8'h00);
    repeat (30) @(posedge clk);
    sample_valid <= 1'b1;
    h.rdn(7'h2D, 8'h09, 3);
    for (n = 0; n < 3; n = n + 1)
      chk(h.rd[n], 8'h00);
    chk({dut_u.sample_ready, dut_u.osc_run}, 8'h00);
    h.wr(7'h2C, 8'h0B, 8'h0F);
    chk({7'h00, h.nak}, 8'h01);
    strap <= 1'b0;
    h.wr(7'h2C, 8'h0B, 8'h0F);
    h.rdn(7'h2C, 8'h0B, 1);
    chk({h.nak, h.rd[0][6:0]}, 8'h0F);
    $display("reset and address done");
    h.wr(7'h2C, 8'h09, 8'h3D);
    chk({dut_u.selftest_drive, dut_u.osc_run}, 8'h01);
    repeat (4500) @(posedge clk);
    h.rdn(7'h2C, 8'h06, 1);
    chk(h.rd[0] & 8'h01, 8'h01);
    h.rdn(7'h2C, 8'h00, 7);
    chk(h.rd[0], 8'h00);
    chk(h.rd[2] - h.rd[0], 8'h01);
    chk(h.rd[4] - h.rd[0], 8'h02);
    chk(h.rd[3] ^ h.rd[5], 8'h00);
    chk(h.rd[6] & 8'h01, 8'h00);
    repeat (9000) @(posedge clk);
    h.rdn(7'h2C, 8'h06, 1);
    chk(h.rd[0], 8'h05);
    h.rdn(7'h2C, 8'h06, 1);
    chk(h.rd[0], 8'h01);
    $display("continuous done");
    h.rdn(7'h2C, 8'h00, 1);
    chk(h.rd[0], 8'h08);
    repeat (5000) @(posedge clk);
    h.rdn(7'h2C, 8'h06, 1);
    chk(h.rd[0] & 8'h04, 8'h04);
    h.rdn(7'h2C, 8'h00, 6);
    chk(h.rd[0], 8'h08);
    $display("lock done");
    h.wr(7'h2C, 8'h09, 8'h32);
    chk({dut_u.selftest_drive, dut_u.osc_run}, 8'h03);
    repeat (500) @(posedge clk);
    h.rdn(7'h2C, 8'h06, 1);
    chk(h.rd[0] & 8'h01, 8'h01);
    keep = 8'h00;
    repeat (5000) @(posedge clk)
      keep = keep + dut_u.measure_start;
    chk(keep, 8'h00);
    h.wr(7'h2C, 8'h09, 8'h03);
    chk({7'h00, dut_u.osc_run}, 8'h00);
    h.wr(7'h2C, 8'h09, 8'h3D);
    h.wr(7'h2C, 8'h09, 8'h00);
    chk({7'h00, dut_u.osc_run}, 8'h00);
    $display("modes done");
    h.wr(7'h2C, 8'h09, 8'h3D);
    h.wr(7'h2C, 8'h0A, 8'h80);
    h.rdn(7'h2C, 8'h09, 3);
    chk(h.rd[0] | h.rd[2], 8'h00);
    chk({7'h00, dut_u.osc_run}, 8'h00);
    $display("soft reset done");
    end_sim;
  end
endmodule
bind mag_core mag_core_props #(.POR_CYC(POR_CYC)) props_u (.clk(clk), .arst_n(arst_n),
  .sda_out(sda_out), .sda_oe(sda_oe), .measure_start(measure_start),
  .setreset_pulse(setreset_pulse), .selftest_drive(selftest_drive), .osc_run(osc_run),
  .bus_ready(bus_ready));

// File: meas_timer.v
// Purpose: paces measurement starts and sensor set/reset pulses
// Assumes: mode and rate come straight from the control register
// Notes:   counts above 4096 cycles are parameters so benches can shorten them
`timescale 1ns/100ps
`include "mag_defs.vh"
module meas_timer #(
  parameter P10  = `RATE_10HZ_CYCLES,
  parameter P50  = `RATE_50HZ_CYCLES,
  parameter P100 = `RATE_100HZ_CYCLES,
  parameter P200 = `RATE_200HZ_CYCLES
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [1:0] mode,
  input  wire [1:0] rate,
  input  wire [7:0] sr_period,
  input  wire       busy,
  output reg        start_pulse,
  output reg        setreset_pulse
);
  reg [21:0] tick_reg;
  reg [9:0]  sr_cnt_reg;
  reg [1:0]  mode_d_reg;
  wire       go;
  wire [9:0] sr_limit;

  // rate field to period in cycles
  function [21:0] period_of;
    input [1:0] r;
    begin
      case (r)
        2'h0:    period_of = P10[21:0];
        2'h1:    period_of = P50[21:0];
        2'h2:    period_of = P100[21:0];
        default: period_of = P200[21:0];
      endcase
    end
  endfunction

  assign sr_limit = {sr_period, 2'h0} + 10'h005;
  // continuous: one start per period; self-test: one start on entry
  assign go = (mode == `MODE_CONT && tick_reg >= period_of(rate) - 22'h000001 && !busy) |
              (mode == `MODE_SELFTEST && mode_d_reg != `MODE_SELFTEST);

  // the tick counter is held at zero outside continuous mode; in standby that stands for the halted oscillator
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg       <= 22'h000000;
      sr_cnt_reg     <= 10'h000;
      mode_d_reg     <= `MODE_STANDBY;
      start_pulse    <= 1'b0;
      setreset_pulse <= 1'b0;
    end else begin
      mode_d_reg     <= mode;
      start_pulse    <= go;
      setreset_pulse <= 1'b0;
      if (mode != `MODE_CONT || go) begin
        tick_reg <= 22'h000000;
      end else if (tick_reg < period_of(rate)) begin
        tick_reg <= tick_reg + 22'h000001;
      end
      if (go) begin
        if (sr_cnt_reg >= sr_limit - 10'h001) begin
          sr_cnt_reg     <= 10'h000;
          setreset_pulse <= 1'b1;
        end else begin
          sr_cnt_reg <= sr_cnt_reg + 10'h001;
        end
      end
    end
  end
endmodule

// File: sample_fifo.v
// Purpose: word buffer between the converter stream and the result assembler
// Assumes: single clock, source and sink both on clk
// Notes:   in_ready comes from a flip-flop so back-pressure is glitch free
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  wire [AW:0]     count_next;

  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign out_valid  = (count_reg != {(AW+1){1'b0}});
  assign out_data   = mem[rd_ptr_reg];
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage, no reset needed on data words
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready  <= (count_next != DEPTH);
    end
  end
endmodule
